// File: common/ccs_params.svh
// constants for the channel configuration and synthesizer register bank
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH
`define CCS_ADDR_W 12
`define CCS_IDX_CHCFG 10'h058
`define CCS_IDX_BAND_INT 10'h059
`define CCS_IDX_FRAC_LO 10'h05a
`define CCS_IDX_FRAC_MID 10'h05b
`define CCS_IDX_FRAC_HI 10'h05c
`define CCS_RST_CHCFG 7'h04
`define CCS_RST_BAND_INT 8'h93
`define CCS_RST_FRAC_LO 8'hf3
`define CCS_RST_FRAC_MID 8'h07
`define CCS_RST_FRAC_HI 5'h09
`define CCS_EXT_HI 6
`define CCS_EXT_LO 5
`define CCS_RET_BIT 4
`define CCS_NOC_HI 3
`define CCS_NOC_LO 2
`define CCS_MT_HI 1
`define CCS_MT_LO 0
`define CCS_BAND_HI 7
`define CCS_BAND_LO 6
`define CCS_INT_HI 5
`define CCS_SPUR_BIT 5
`define CCS_FHI_HI 4
`define CCS_EXT_RSVD 2'h3
`define CCS_BAND_UNUSED 2'h0
`endif

// File: common/ccs_pkg.sv
// types for the channel configuration and synthesizer register bank
package ccs_pkg;
  typedef enum logic [2:0] {
    CCS_ST_IDLE = 3'h1,
    CCS_ST_POLL = 3'h2,
    CCS_ST_RUN = 3'h4
  } ccs_state_t;
  typedef struct packed {
    logic framing_en;
    logic frame_sync_event_irq_en;
    logic mid_irq_en;
    logic eom_irq_en;
    logic sync_to_en;
    logic other_to_en;
    logic wu_pattern_en;
    logic wu_level_only;
  } ccs_proc_ctl_t;
  typedef struct packed {
    logic [1:0] slave_ch;
    logic [2:0] poll_ch_mask;
    logic slave_fsk;
    logic poll_first_fsk;
    logic poll_second_fsk;
  } ccs_chan_ctl_t;
  typedef struct packed {
    logic [1:0] band;
    logic [5:0] div_int;
    logic [20:0] frac;
    logic spur_en;
  } ccs_synth_t;
endpackage

// File: design/ccs_frac_commit.sv
// shadow bytes of the channel 1 fraction and their joint commit
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_frac_commit import ccs_pkg::*; (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] wr_i,
  input wire logic [7:0] data_i,
  output logic [20:0] shadow_o,
  output logic [20:0] frac_o
);
  logic [2:0] seen_reg;
  logic [2:0] seen_next;
  logic [20:0] shadow_next;

  always_comb begin
    shadow_next = shadow_o;
    if (wr_i[0]) shadow_next[7:0] = data_i;
    if (wr_i[1]) shadow_next[15:8] = data_i;
    if (wr_i[2]) shadow_next[20:16] = data_i[`CCS_FHI_HI:0];
    seen_next = seen_reg | wr_i;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shadow_o <= {`CCS_RST_FRAC_HI, `CCS_RST_FRAC_MID, `CCS_RST_FRAC_LO};
      frac_o <= {`CCS_RST_FRAC_HI, `CCS_RST_FRAC_MID, `CCS_RST_FRAC_LO};
      seen_reg <= 3'h0;
    end else begin
      shadow_o <= shadow_next;
      if (&seen_next) begin
        frac_o <= shadow_next;
        seen_reg <= 3'h0;
      end else begin
        seen_reg <= seen_next;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_FRAC_COMMIT: assert property (
    (seen_reg | wr_i) != 3'h7 |=> $stable(frac_o))
    else $error("fraction changed before all three bytes were written");
  AST_FRAC_LAYOUT: assert property (
    wr_i == 3'h4 && seen_reg == 3'h3 |=>
      frac_o[20:16] == $past(data_i[4:0]) && frac_o[15:0] == $past(shadow_o[15:0]))
    else $error("committed fraction does not match its bytes");
endmodule // ccs_frac_commit

// File: design/ccs_mode_decode.sv
// decoder from the channel configuration field to block controls
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_mode_decode import ccs_pkg::*; (
  input wire logic [6:0] cfg_i,
  output ccs_proc_ctl_t proc_o,
  output ccs_chan_ctl_t chan_o
);
  logic [1:0] ext;
  logic [1:0] channel_count_select;
  logic [1:0] mt;
  assign ext = cfg_i[`CCS_EXT_HI:`CCS_EXT_LO];
  assign channel_count_select = cfg_i[`CCS_NOC_HI:`CCS_NOC_LO];
  assign mt = cfg_i[`CCS_MT_HI:`CCS_MT_LO];

  always_comb begin
    proc_o = '1;
    proc_o.wu_level_only = 1'b0;
    if (ext[0]) begin
      proc_o.framing_en = 1'b0;
      proc_o.frame_sync_event_irq_en = 1'b0;
      proc_o.mid_irq_en = 1'b0;
      proc_o.eom_irq_en = 1'b0;
      proc_o.other_to_en = 1'b0;
      proc_o.wu_pattern_en = 1'b0;
    end else if (ext[1]) begin
      proc_o = '0;
      proc_o.wu_level_only = 1'b1;
    end
  end

  always_comb begin
    chan_o.slave_ch = (channel_count_select[1]) ? channel_count_select : 2'h1;
    chan_o.poll_ch_mask = {channel_count_select == 2'h3, channel_count_select[1], 1'b1};
    chan_o.slave_fsk = mt[0];
    chan_o.poll_first_fsk = mt[1] ^ mt[0];
    chan_o.poll_second_fsk = mt[0];
  end
endmodule // ccs_mode_decode

// File: design/ccs_top.sv
// channel configuration and channel 1 synthesizer registers on apb
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_top import ccs_pkg::*; (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [`CCS_ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic POLL_START_I,
  input wire logic POLL_STOP_I,
  input wire logic PAYLOAD_FOUND_I,
  input wire logic END_OF_MESSAGE_EVENT_I,
  output ccs_proc_ctl_t PROC_CTL_O,
  output ccs_chan_ctl_t CHAN_CTL_O,
  output ccs_synth_t SYNTH_O,
  output logic RUN_SELF_POLL_O,
  output logic SELF_POLL_O
);
  logic [6:0] chcfg_reg;
  logic [7:0] band_int_reg;
  logic spur_reg;
  logic [20:0] frac_shadow;
  logic [20:0] frac_active;
  ccs_proc_ctl_t proc_dec;
  ccs_chan_ctl_t chan_dec;
  ccs_state_t state_reg;
  ccs_state_t state_next;
  logic setup;
  logic access_done;
  logic wr_ok;
  logic [4:0] hit;
  logic mapped;
  logic bad_data;
  logic [7:0] rd_byte;
  logic [2:0] frac_wr;
  logic eom_ok;

  // register index to byte address
  function automatic logic [`CCS_ADDR_W-1:0] byte_addr(
    input logic [9:0] idx
  );
    byte_addr = {idx, 2'h0};
  endfunction

  // apb handshake: one setup cycle, one access cycle, no wait states
  assign setup = PSEL_I && !PENABLE_I;
  assign access_done = PSEL_I && PENABLE_I && PREADY_O;
  assign wr_ok = access_done && PWRITE_I && !PSLVERR_O;

  always_comb begin
    hit[0] = PADDR_I == byte_addr(`CCS_IDX_CHCFG);
    hit[1] = PADDR_I == byte_addr(`CCS_IDX_BAND_INT);
    hit[2] = PADDR_I == byte_addr(`CCS_IDX_FRAC_LO);
    hit[3] = PADDR_I == byte_addr(`CCS_IDX_FRAC_MID);
    hit[4] = PADDR_I == byte_addr(`CCS_IDX_FRAC_HI);
    mapped = |hit;
  end

  // reserved field codes are refused with an error, nothing is stored
  always_comb begin
    bad_data = 1'b0;
    if (PWRITE_I && hit[0] &&
        PWDATA_I[`CCS_EXT_HI:`CCS_EXT_LO] == `CCS_EXT_RSVD) begin
      bad_data = 1'b1;
    end
    if (PWRITE_I && hit[1] &&
        PWDATA_I[`CCS_BAND_HI:`CCS_BAND_LO] == `CCS_BAND_UNUSED) begin
      bad_data = 1'b1;
    end
  end

  // readback; unused bits are zero
  always_comb begin
    rd_byte = 8'h00;
    case (1'b1)
      hit[0]: rd_byte = {1'b0, chcfg_reg};
      hit[1]: rd_byte = band_int_reg;
      hit[2]: rd_byte = frac_shadow[7:0];
      hit[3]: rd_byte = frac_shadow[15:8];
      hit[4]: rd_byte = {2'h0, spur_reg, frac_shadow[20:16]};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else if (setup) begin
      PREADY_O <= 1'b1;
      PSLVERR_O <= !mapped || bad_data;
      PRDATA_O <= {24'h00_0000, rd_byte};
    end else if (access_done) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end
  end

  // channel configuration register
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      chcfg_reg <= `CCS_RST_CHCFG;
    end else if (wr_ok && hit[0]) begin
      chcfg_reg <= PWDATA_I[6:0];
    end
  end

  // band select and integer divider
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      band_int_reg <= `CCS_RST_BAND_INT;
    end else if (wr_ok && hit[1]) begin
      band_int_reg <= PWDATA_I[7:0];
    end
  end

  // spur compensation takes effect at once
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      spur_reg <= 1'b0;
    end else if (wr_ok && hit[4]) begin
      spur_reg <= PWDATA_I[`CCS_SPUR_BIT];
    end
  end

  assign frac_wr = {wr_ok && hit[4], wr_ok && hit[3], wr_ok && hit[2]};

  ccs_frac_commit u_frac (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .wr_i(frac_wr),
    .data_i(PWDATA_I[7:0]),
    .shadow_o(frac_shadow),
    .frac_o(frac_active)
  );

  ccs_mode_decode u_dec (
    .cfg_i(chcfg_reg),
    .proc_o(proc_dec),
    .chan_o(chan_dec)
  );

  // registered controls toward the receiver and synthesizer
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PROC_CTL_O <= '0;
      CHAN_CTL_O <= '0;
    end else begin
      PROC_CTL_O <= proc_dec;
      CHAN_CTL_O <= chan_dec;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SYNTH_O <= '0;
    end else begin
      SYNTH_O.band <= band_int_reg[`CCS_BAND_HI:`CCS_BAND_LO];
      SYNTH_O.div_int <= band_int_reg[`CCS_INT_HI:0];
      SYNTH_O.frac <= frac_active;
      SYNTH_O.spur_en <= spur_reg;
    end
  end

  // end of message counts only while framing is running
  assign eom_ok = END_OF_MESSAGE_EVENT_I && proc_dec.eom_irq_en;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CCS_ST_IDLE: begin
        if (POLL_START_I) state_next = CCS_ST_POLL;
      end
      CCS_ST_POLL: begin
        if (POLL_STOP_I) state_next = CCS_ST_IDLE;
        else if (PAYLOAD_FOUND_I) state_next = CCS_ST_RUN;
      end
      CCS_ST_RUN: begin
        if (POLL_STOP_I) begin
          state_next = CCS_ST_IDLE;
        end else if (eom_ok && chcfg_reg[`CCS_RET_BIT]) begin
          state_next = CCS_ST_POLL;
        end else begin
          state_next = CCS_ST_RUN;
        end
      end
      default: state_next = CCS_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg <= CCS_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RUN_SELF_POLL_O <= 1'b0;
      SELF_POLL_O <= 1'b0;
    end else begin
      RUN_SELF_POLL_O <= state_next == CCS_ST_RUN;
      SELF_POLL_O <= state_next == CCS_ST_POLL;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  AST_EXT_RSVD: assert property (
    chcfg_reg[`CCS_EXT_HI:`CCS_EXT_LO] != `CCS_EXT_RSVD)
    else $error("reserved external processing code stored");
  AST_EXT_NONE: assert property (
    RSTN_I && chcfg_reg[6:5] == 2'h0 |=> PROC_CTL_O.framing_en &&
      PROC_CTL_O.other_to_en && PROC_CTL_O.wu_pattern_en)
    else $error("blocks deactivated without external processing");
  AST_EXT_CHIP: assert property (
    RSTN_I && chcfg_reg[6:5] == 2'h1 |=> !PROC_CTL_O.framing_en &&
      !PROC_CTL_O.eom_irq_en && PROC_CTL_O.sync_to_en &&
      !PROC_CTL_O.other_to_en && !PROC_CTL_O.wu_pattern_en)
    else $error("chip data mode controls wrong");
  AST_EXT_MF: assert property (
    RSTN_I && chcfg_reg[6:5] == 2'h2 |=> !PROC_CTL_O.frame_sync_event_irq_en &&
      !PROC_CTL_O.sync_to_en && !PROC_CTL_O.other_to_en &&
      PROC_CTL_O.wu_level_only)
    else $error("matched filter mode controls wrong");
  AST_RUN_STAY: assert property (
    state_reg == CCS_ST_RUN && !POLL_STOP_I && !chcfg_reg[4]
      |=> RUN_SELF_POLL_O && state_reg == CCS_ST_RUN)
    else $error("run state left with polling return disabled");
  AST_RUN_LEAVE: assert property (
    state_reg == CCS_ST_RUN && !POLL_STOP_I && eom_ok && chcfg_reg[4]
      |=> SELF_POLL_O && !RUN_SELF_POLL_O)
    else $error("run state kept after end of message");
  AST_NOC: assert property (
    RSTN_I |=> CHAN_CTL_O.poll_ch_mask ==
      ($past(chcfg_reg[3:2]) == 2'h3 ? 3'h7 :
      $past(chcfg_reg[3:2]) == 2'h2 ? 3'h3 : 3'h1))
    else $error("polling channel set does not follow channel count");
  AST_MT: assert property (
    RSTN_I && chcfg_reg[1:0] == 2'h2 |=> !CHAN_CTL_O.slave_fsk &&
      CHAN_CTL_O.poll_first_fsk && !CHAN_CTL_O.poll_second_fsk)
    else $error("modulation pair wrong for code 10");
  AST_BAND: assert property (
    band_int_reg[7:6] != 2'h0)
    else $error("unused band code stored");
  AST_SPUR: assert property (
    wr_ok && hit[4] |-> ##2 SYNTH_O.spur_en == $past(PWDATA_I[5], 2))
    else $error("spur compensation does not follow write");
  AST_APB_DONE: assert property (
    RSTN_I && setup |=> PREADY_O ##1 !PREADY_O)
    else $error("apb answer not in the access cycle");
endmodule // ccs_top

// File: dv/ccs_host_model.sv
// apb host model that programs the register bank
`timescale 1ns/1ps
module ccs_host_model (
  input wire logic clk_i,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
  end
  // entered just after a rising edge; one idle edge follows each transfer
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d, output logic [31:0] rd,
                      output logic err);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= {24'h00_0000, d};
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    @(posedge clk_i);
  endtask
  // integer part, 21-bit fraction split low to high, band on top
  task automatic prog_ch1(input logic [1:0] band, input logic [5:0] div,
                          input logic [20:0] frac, input logic spur);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, 12'h164, {band, div}, rd, err);
    xfer(1'b1, 12'h168, frac[7:0], rd, err);
    xfer(1'b1, 12'h16c, frac[15:8], rd, err);
    xfer(1'b1, 12'h170, {2'b00, spur, frac[20:16]}, rd, err);
  endtask
endmodule // ccs_host_model

// File: dv/test_channel_config_synth_regs.sv
// self-checking bench for the channel configuration register bank
`timescale 1ns/1ps
`define CHK(a, e) begin \
  compares++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (a), (e)); \
  end \
end
module test_channel_config_synth_regs import ccs_pkg::*;;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic poll_start, poll_stop, payload, end_of_message_event, run_sp, sp;
  ccs_proc_ctl_t proc_ctl;
  ccs_chan_ctl_t chan_ctl;
  ccs_synth_t synth;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  ccs_top dut_u (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .POLL_START_I(poll_start),
    .POLL_STOP_I(poll_stop), .PAYLOAD_FOUND_I(payload),
    .END_OF_MESSAGE_EVENT_I(end_of_message_event), .PROC_CTL_O(proc_ctl),
    .CHAN_CTL_O(chan_ctl), .SYNTH_O(synth), .RUN_SELF_POLL_O(run_sp),
    .SELF_POLL_O(sp));
  ccs_host_model host_u (.clk_i(clk), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  // one transfer, then one more edge so the decoded outputs have landed
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [31:0] exp_rd, input logic exp_err);
    logic [31:0] rd;
    logic err;
    host_u.xfer(w, a, d, rd, err);
    if (!w) `CHK(rd, exp_rd)
    `CHK(err, exp_err)
    @(posedge clk);
  endtask
  // order of m: start, stop, payload found, end of message
  task automatic pulse(input logic [3:0] m);
    {poll_start, poll_stop, payload, end_of_message_event} <= m;
    @(posedge clk);
    {poll_start, poll_stop, payload, end_of_message_event} <= 4'h0;
    @(posedge clk);
  endtask
  task automatic t_reset();
    logic [7:0] rv [5] = '{8'h04, 8'h93, 8'hf3, 8'h07, 8'h09};
    `CHK(proc_ctl, 8'hfe)
    `CHK(chan_ctl, 8'h48)
    `CHK(synth, {2'h2, 6'h13, 21'h9_07f3, 1'b0})
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 12'h160 + 12'(4 * i), 8'h00, {24'h00_0000, rv[i]}, 1'b0);
    end
    $display("reset test done");
  endtask
  task automatic t_chcfg();
    logic [7:0] c;
    logic [2:0] mk;
    logic [1:0] sc;
    logic f1;
    for (int n = 0; n < 4; n++) begin
      for (int m = 0; m < 4; m++) begin
        c = {4'h0, n[1:0], m[1:0]};
        mk = n < 2 ? 3'b001 : (n == 2 ? 3'b011 : 3'b111);
        sc = n < 2 ? 2'h1 : n[1:0];
        f1 = (m == 1 || m == 2);
        acc(1'b1, 12'h160, c | 8'h80, 32'h0000_0000, 1'b0);
        acc(1'b0, 12'h160, 8'h00, {24'h00_0000, c}, 1'b0);
        `CHK(chan_ctl, {sc, mk, m[0], f1, m[0]})
      end
    end
    acc(1'b1, 12'h160, 8'h24, 32'h0000_0000, 1'b0);
    `CHK(proc_ctl, 8'h08)
    acc(1'b1, 12'h160, 8'h44, 32'h0000_0000, 1'b0);
    `CHK(proc_ctl, 8'h01)
    acc(1'b1, 12'h160, 8'h64, 32'h0000_0000, 1'b1);
    acc(1'b0, 12'h160, 8'h00, 32'h0000_0044, 1'b0);
    acc(1'b1, 12'h160, 8'h04, 32'h0000_0000, 1'b0);
    `CHK(proc_ctl, 8'hfe)
    $display("channel configuration test done");
  endtask
  task automatic t_synth();
    acc(1'b1, 12'h164, 8'h15, 32'h0000_0000, 1'b1);
    acc(1'b0, 12'h164, 8'h00, 32'h0000_0093, 1'b0);
    for (int b = 1; b < 4; b++) begin
      acc(1'b1, 12'h164, {b[1:0], 6'h2a}, 32'h0000_0000, 1'b0);
      `CHK(synth.band, b[1:0])
      `CHK(synth.div_int, 6'h2a)
    end
    acc(1'b0, 12'h174, 8'h00, 32'h0000_0000, 1'b1);
    acc(1'b1, 12'h161, 8'hff, 32'h0000_0000, 1'b1);
    acc(1'b1, 12'h168, 8'h5a, 32'h0000_0000, 1'b0);
    acc(1'b1, 12'h16c, 8'h3c, 32'h0000_0000, 1'b0);
    `CHK(synth.frac, 21'h9_07f3)
    acc(1'b0, 12'h168, 8'h00, 32'h0000_005a, 1'b0);
    acc(1'b1, 12'h170, 8'hf6, 32'h0000_0000, 1'b0);
    `CHK(synth.frac, 21'h16_3c5a)
    `CHK(synth.spur_en, 1'b1)
    acc(1'b0, 12'h170, 8'h00, 32'h0000_0036, 1'b0);
    acc(1'b1, 12'h170, 8'h01, 32'h0000_0000, 1'b0);
    `CHK(synth.spur_en, 1'b0)
    `CHK(synth.frac, 21'h16_3c5a)
    // high byte was still pending, so low and mid complete the set first
    host_u.prog_ch1(2'h3, 6'h21, 21'h1a_bcde, 1'b0);
    @(posedge clk);
    `CHK(synth.frac, 21'h01_bcde)
    host_u.prog_ch1(2'h3, 6'h21, 21'h1a_bcde, 1'b0);
    @(posedge clk);
    `CHK(synth, {2'h3, 6'h21, 21'h1a_bcde, 1'b0})
    $display("synthesizer test done");
  endtask
  task automatic t_poll();
    pulse(4'h8);
    `CHK({sp, run_sp}, 2'b10)
    pulse(4'h2);
    `CHK(run_sp, 1'b1)
    pulse(4'h1);
    `CHK(run_sp, 1'b1)
    acc(1'b1, 12'h160, 8'h14, 32'h0000_0000, 1'b0);
    pulse(4'h1);
    `CHK({sp, run_sp}, 2'b10)
    pulse(4'h2);
    acc(1'b1, 12'h160, 8'h34, 32'h0000_0000, 1'b0);
    pulse(4'h1);
    `CHK(run_sp, 1'b1)
    pulse(4'h4);
    `CHK({sp, run_sp}, 2'b00)
    pulse(4'h8);
    `CHK(sp, 1'b1)
    pulse(4'h4);
    `CHK({sp, run_sp}, 2'b00)
    $display("polling test done");
  endtask
  // reset in mid-run returns every register to its reset value
  task automatic t_rerun();
    acc(1'b1, 12'h160, 8'h5b, 32'h0000_0000, 1'b0);
    rstn <= 1'b0;
    @(posedge clk);
    `CHK(proc_ctl, 8'h00)
    `CHK(synth, 30'h0000_0000)
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(proc_ctl, 8'hfe)
    `CHK(chan_ctl, 8'h48)
    `CHK(synth, {2'h2, 6'h13, 21'h9_07f3, 1'b0})
    acc(1'b0, 12'h160, 8'h00, 32'h0000_0004, 1'b0);
    $display("reset in run test done");
  endtask
  initial begin
    rstn = 1'b0;
    {poll_start, poll_stop, payload, end_of_message_event} = 4'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_chcfg();
    t_synth();
    t_poll();
    t_rerun();
    close_out();
  end
endmodule // test_channel_config_synth_regs
